// [shared/asramc_pkg.sv]
package asramc_pkg;
  // ==========================================================
  // Geometry of the memory outside.
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int WORDS = 262144;

  // ==========================================================
  // Timing of the 45 ns speed grade, in ns, and the clock period.
  localparam int CLK_PERIOD_NS = 5;
  localparam int READ_CYCLE_MIN_NS = 45;
  localparam int WRITE_CYCLE_MIN_NS = 45;
  localparam int WRITE_PULSE_MIN_NS = 35;
  localparam int OUTPUT_VALID_NS = 45;

  // Least times round up to whole cycles.
  function automatic int ceil_cycles(input int ns);
    ceil_cycles = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] READ_CYCLES =
    CNT_W'(ceil_cycles(READ_CYCLE_MIN_NS));
  localparam logic [CNT_W-1:0] WRITE_CYCLES =
    CNT_W'(ceil_cycles(WRITE_CYCLE_MIN_NS));
  localparam logic [CNT_W-1:0] WRITE_PULSE_CYCLES =
    CNT_W'(ceil_cycles(WRITE_PULSE_MIN_NS));
  localparam logic [CNT_W-1:0] READ_SAMPLE_CYCLES =
    CNT_W'(ceil_cycles(OUTPUT_VALID_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  typedef enum logic [1:0] {
    ASRAMC_IDLE,
    ASRAMC_READ,
    ASRAMC_WRITE,
    ASRAMC_RECOVER
  } asramc_state_t;
endpackage

// [logic/asramc_timer.sv]
// ==========================================================
// Down counter that paces the read and write-strobe phases of an access.
module asramc_timer (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic load_in,
  input wire logic [asramc_pkg::CNT_W-1:0] value_in,
  output logic [asramc_pkg::CNT_W-1:0] count_out
);
  logic [asramc_pkg::CNT_W-1:0] next_count;

  // Load wins over counting so a new phase never inherits old time.
  always_comb begin
    if (load_in) begin
      next_count = value_in;
    end else if (count_out != asramc_pkg::CNT_ZERO) begin
      next_count = count_out - asramc_pkg::CNT_ONE;
    end else begin
      next_count = count_out;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= asramc_pkg::CNT_ZERO;
    end else begin
      count_out <= next_count;
    end
  end
endmodule

// [logic/asramc_ctrl.sv]
// Contract
// - Write spans overlap of select, strobe, lanes.
// - Hold write data across terminating edge.
// - Never drive data while memory drives.
// - Read cycle lasts at least 45 ns.
// - Write cycle lasts at least 45 ns.
// - Write strobe low at least 35 ns.
module asramc_ctrl (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [asramc_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [asramc_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic [1:0] req_lane_en_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [asramc_pkg::DATA_W-1:0] rsp_rdata_out,
  output logic [asramc_pkg::ADDR_W-1:0] word_addr_out,
  output logic chip_sel_n_out,
  output logic write_strobe_n_out,
  output logic out_drive_n_out,
  output logic low_lane_sel_n_out,
  output logic high_lane_sel_n_out,
  input wire logic [asramc_pkg::DATA_W-1:0] data_io_in,
  output logic [asramc_pkg::DATA_W-1:0] data_io_out,
  output logic data_io_oe_n_out
);
  // ==========================================================
  // State and pin registers.
  asramc_pkg::asramc_state_t state, next_state;
  logic [asramc_pkg::CNT_W-1:0] count;
  logic timer_load;
  logic [asramc_pkg::CNT_W-1:0] timer_value;
  logic next_ready, next_rsp_valid;
  logic [asramc_pkg::DATA_W-1:0] next_rdata, next_wdata;
  logic [asramc_pkg::ADDR_W-1:0] next_addr;
  logic next_cs_n, next_we_n, next_oe_n;
  logic next_low_sel_n, next_high_sel_n, next_bus_oe_n;
  logic [asramc_pkg::CNT_W-1:0] elapsed, next_elapsed;
  localparam logic [asramc_pkg::CNT_W-1:0] CNT_ONE_L = asramc_pkg::CNT_ONE;

  asramc_timer u_timer (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .load_in(timer_load),
    .value_in(timer_value),
    .count_out(count)
  );

  // ==========================================================
  // Access sequencer. Every control pin is registered, so the pins
  // change only on clock edges and the memory sees clean phases.
  always_comb begin
    next_state = state;
    next_ready = req_ready_out;
    next_rsp_valid = 1'b0;
    next_rdata = rsp_rdata_out;
    next_wdata = data_io_out;
    next_addr = word_addr_out;
    next_cs_n = chip_sel_n_out;
    next_we_n = write_strobe_n_out;
    next_oe_n = out_drive_n_out;
    next_low_sel_n = low_lane_sel_n_out;
    next_high_sel_n = high_lane_sel_n_out;
    next_bus_oe_n = data_io_oe_n_out;
    // The age saturates, so a long idle spell never wraps to a short one.
    next_elapsed = (elapsed == {asramc_pkg::CNT_W{1'b1}}) ? elapsed
      : elapsed + CNT_ONE_L;
    timer_load = 1'b0;
    timer_value = asramc_pkg::CNT_ZERO;
    unique case (state)
      asramc_pkg::ASRAMC_IDLE: begin
        if (req_valid_in && req_ready_out) begin
          next_ready = 1'b0;
          next_addr = req_addr_in;
          next_cs_n = 1'b0;
          next_low_sel_n = ~req_lane_en_in[0];
          next_high_sel_n = ~req_lane_en_in[1];
          next_elapsed = asramc_pkg::CNT_ZERO;
          timer_load = 1'b1;
          if (req_write_in) begin
            // Output drive stays high on writes, so the memory never
            // drives while our data is on the bus.
            // With no lane enabled no write may begin, so the strobe
            // stays high and the cycle is a plain no-access one.
            next_we_n = ~|req_lane_en_in;
            next_oe_n = 1'b1;
            next_wdata = req_wdata_in;
            next_bus_oe_n = 1'b0;
            timer_value = asramc_pkg::WRITE_PULSE_CYCLES;
            next_state = asramc_pkg::ASRAMC_WRITE;
          end else begin
            next_we_n = 1'b1;
            next_oe_n = 1'b0;
            next_bus_oe_n = 1'b1;
            timer_value = asramc_pkg::READ_SAMPLE_CYCLES;
            next_state = asramc_pkg::ASRAMC_READ;
          end
        end
      end
      asramc_pkg::ASRAMC_READ: begin
        if (count == asramc_pkg::CNT_ZERO) begin
          // Sampled after the full access time; lanes left off are 0.
          next_rdata = data_io_in;
          if (low_lane_sel_n_out) begin
            next_rdata[asramc_pkg::LANE_W-1:0] = 8'h00;
          end
          if (high_lane_sel_n_out) begin
            next_rdata[asramc_pkg::DATA_W-1:asramc_pkg::LANE_W] = 8'h00;
          end
          next_rsp_valid = 1'b1;
          next_cs_n = 1'b1;
          next_oe_n = 1'b1;
          next_low_sel_n = 1'b1;
          next_high_sel_n = 1'b1;
          next_state = asramc_pkg::ASRAMC_RECOVER;
        end
      end
      asramc_pkg::ASRAMC_WRITE: begin
        if (count == asramc_pkg::CNT_ZERO) begin
          // Strobe rises first; data stays on the bus one cycle more.
          next_we_n = 1'b1;
          next_state = asramc_pkg::ASRAMC_RECOVER;
        end
      end
      asramc_pkg::ASRAMC_RECOVER: begin
        next_cs_n = 1'b1;
        next_oe_n = 1'b1;
        next_low_sel_n = 1'b1;
        next_high_sel_n = 1'b1;
        next_bus_oe_n = 1'b1;
        if (!next_rsp_valid && rsp_valid_out == 1'b0 &&
            elapsed >= asramc_pkg::READ_CYCLES - CNT_ONE_L) begin
          next_ready = 1'b1;
          next_state = asramc_pkg::ASRAMC_IDLE;
        end
      end
    endcase
  end

  // Every pin and status output comes straight from a flip-flop.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= asramc_pkg::ASRAMC_IDLE;
      req_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 16'h0000;
      data_io_out <= 16'h0000;
      word_addr_out <= 18'h0_0000;
      chip_sel_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      out_drive_n_out <= 1'b1;
      low_lane_sel_n_out <= 1'b1;
      high_lane_sel_n_out <= 1'b1;
      data_io_oe_n_out <= 1'b1;
      elapsed <= 5'h00;
    end else begin
      state <= next_state;
      req_ready_out <= next_ready;
      rsp_valid_out <= next_rsp_valid;
      rsp_rdata_out <= next_rdata;
      data_io_out <= next_wdata;
      word_addr_out <= next_addr;
      chip_sel_n_out <= next_cs_n;
      write_strobe_n_out <= next_we_n;
      out_drive_n_out <= next_oe_n;
      low_lane_sel_n_out <= next_low_sel_n;
      high_lane_sel_n_out <= next_high_sel_n;
      data_io_oe_n_out <= next_bus_oe_n;
      elapsed <= next_elapsed;
    end
  end

  // ==========================================================
  // Checks on the pins and status outputs that this controller drives.
  no_contention_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    !data_io_oe_n_out |-> out_drive_n_out)
    else $error("Controller drives data while memory may drive.");

  strobe_width_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $fell(write_strobe_n_out) |-> !write_strobe_n_out [*7])
    else $error("Write strobe shorter than 35 ns.");

  data_hold_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $rose(write_strobe_n_out) |->
      !data_io_oe_n_out && $stable(data_io_out))
    else $error("Write data not held at strobe rise.");

  write_frame_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $fell(write_strobe_n_out) |-> !chip_sel_n_out &&
      !(low_lane_sel_n_out && high_lane_sel_n_out))
    else $error("Write begun without select or lane.");

  read_cycle_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $fell(out_drive_n_out) |-> !chip_sel_n_out [*8] ##1 !chip_sel_n_out)
    else $error("Read cycle shorter than 45 ns.");

  write_cycle_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $fell(write_strobe_n_out) |-> !req_ready_out [*8] ##1 !req_ready_out)
    else $error("Write cycle shorter than 45 ns.");

  read_pins_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    !out_drive_n_out |-> write_strobe_n_out && !chip_sel_n_out)
    else $error("Read with strobe low or chip deselected.");

  read_answer_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $fell(out_drive_n_out) |-> ##10 rsp_valid_out)
    else $error("Read answer not given after access time.");

  idle_release_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    chip_sel_n_out |-> write_strobe_n_out && out_drive_n_out)
    else $error("Strobe active while deselected.");
endmodule

// [testbench/asramc_mem_model.sv]
// ==========================================================
// Behavioural memory that stands at the far side of the pins.
module asramc_mem_model #(
  parameter int ACC_NS = 40
) (
  input wire logic [asramc_pkg::ADDR_W-1:0] word_addr_in,
  input wire logic chip_sel_n_in,
  input wire logic write_strobe_n_in,
  input wire logic out_drive_n_in,
  input wire logic low_lane_sel_n_in,
  input wire logic high_lane_sel_n_in,
  input wire logic ctrl_drive_n_in,
  input wire logic [asramc_pkg::DATA_W-1:0] data_bus_in,
  output logic [asramc_pkg::DATA_W-1:0] drive_out,
  output logic [1:0] drive_en_out,
  output int fault_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic rd;
  logic vld = 1'b0;
  logic [1:0] lanes;
  logic [1:0] wr;
  logic [1:0] wr_q = 2'b00;
  realtime t_we = -1000.0;
  realtime t_cs = -1000.0;

  initial fault_cnt_out = 0;
  // A read needs select low, strobe high and output drive low.
  assign rd = !chip_sel_n_in && write_strobe_n_in
    && !out_drive_n_in;
  assign lanes = ~{high_lane_sel_n_in, low_lane_sel_n_in};
  assign wr = {2{!chip_sel_n_in && !write_strobe_n_in}} & lanes;
  assign drive_en_out = {2{vld && rd}} & lanes;

  // Data is valid only after the access time; a new address restarts it.
  always @(rd, word_addr_in) begin
    vld = 1'b0;
    vld <= #(ACC_NS) rd;
  end

  // Unwritten words answer with a pattern, since their contents are unknown.
  always @(word_addr_in, vld) begin
    drive_out = word_addr_in[15:0] ^ 16'h5A5A;
    if (mem.exists(int'(word_addr_in))) begin
      drive_out = mem[int'(word_addr_in)];
    end
  end

  // Each lane is stored at the edge that ends its write.
  always @(wr) begin
    for (int i = 0; i < 2; i++) begin
      if (wr_q[i] && !wr[i]) begin
        mem[int'(word_addr_in)][i*8 +: 8] =
          data_bus_in[i*8 +: 8];
      end
    end
    wr_q = wr;
  end

  // Strobe width, access spacing and bus fights are counted as faults.
  always @(negedge write_strobe_n_in) t_we = $realtime;
  always @(posedge write_strobe_n_in) begin
    if ($realtime - t_we < asramc_pkg::WRITE_PULSE_MIN_NS) begin
      fault_cnt_out++;
    end
  end
  always @(negedge chip_sel_n_in) begin
    if ($realtime - t_cs < asramc_pkg::READ_CYCLE_MIN_NS) begin
      fault_cnt_out++;
    end
    t_cs = $realtime;
  end
  always @(drive_en_out, ctrl_drive_n_in) begin
    if (drive_en_out != 2'b00 && ctrl_drive_n_in == 1'b0) begin
      fault_cnt_out++;
    end
  end
endmodule

// [testbench/asramc_ctrl_test.sv]
module asramc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals, the design and the far-side memory.
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [17:0] req_addr_in = 18'h0_0000;
  logic [15:0] req_wdata_in = 16'h0000;
  logic [1:0] req_lane_en_in = 2'h0;
  logic req_ready_out, rsp_valid_out, chip_sel_n_out, write_strobe_n_out;
  logic out_drive_n_out, low_lane_sel_n_out, high_lane_sel_n_out;
  logic data_io_oe_n_out;
  logic [15:0] rsp_rdata_out, data_io_out, mem_drive;
  wire logic [15:0] data_io_in;
  logic [15:0] floating = 16'h0000;
  logic [17:0] word_addr_out;
  logic [1:0] mem_en;
  int mem_faults, err_total = 0, check_count = 0;
  logic [31:0] seed = 32'h0001_69F4;
  logic [15:0] shadow [int];
  logic [1:0] known [int];
  logic [17:0] pool [4] = '{18'h0_0000, 18'h3_FFFF, 18'h2_AAAA, 18'h1_5555};

  asramc_ctrl dut (.*);
  asramc_mem_model mem_model (.word_addr_in(word_addr_out),
    .chip_sel_n_in(chip_sel_n_out), .write_strobe_n_in(write_strobe_n_out),
    .out_drive_n_in(out_drive_n_out), .low_lane_sel_n_in(low_lane_sel_n_out),
    .high_lane_sel_n_in(high_lane_sel_n_out),
    .ctrl_drive_n_in(data_io_oe_n_out), .data_bus_in(data_io_in),
    .drive_out(mem_drive), .drive_en_out(mem_en), .fault_cnt_out(mem_faults));

  // A released lane floats; its bits clear in seed toggle each cycle and the bits set in seed hold.
  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign data_io_in[i*8 +: 8] = !data_io_oe_n_out ? data_io_out[i*8 +: 8]
      : mem_en[i] ? mem_drive[i*8 +: 8] : floating[i*8 +: 8];
  end
  always @(posedge mclk_in) floating <= ~floating ^ seed[15:0];

  // Clock and a watchdog sized well beyond the expected run.
  initial forever #2.5 mclk_in = ~mclk_in;
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    test_done();
  end

  // ==========================================================
  // Helpers.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_read(input int a, input logic [1:0] l);
    return {l[1] ? shadow[a][15:8] : 8'h00, l[0] ? shadow[a][7:0] : 8'h00};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle_chk();
    chk(16'({chip_sel_n_out, write_strobe_n_out, out_drive_n_out,
      low_lane_sel_n_out, high_lane_sel_n_out, data_io_oe_n_out,
      req_ready_out, rsp_valid_out}), 16'h00FE);
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One request; reads only ask for lanes whose contents are known.
  task automatic xfer(input logic w, input logic [17:0] a,
                      input logic [15:0] d, input logic [1:0] l);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 50) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    if (!w) l = l & (known.exists(a) ? known[a] : 2'b00);
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_lane_en_in <= l;
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    n = 0;
    if (w) begin
      repeat (4) @(posedge mclk_in);
      #1;
      chk(16'({write_strobe_n_out, out_drive_n_out}),
        16'({~|l, 1'b1}));
      if (!known.exists(a)) known[a] = 2'b00;
      for (int i = 0; i < 2; i++) begin
        if (l[i]) shadow[a][i*8 +: 8] = d[i*8 +: 8];
      end
      known[a] = known[a] | l;
    end else begin
      do begin
        @(posedge mclk_in);
        #1;
        n++;
      end while (rsp_valid_out !== 1'b1 && n < 20);
      chk(16'(n), 16'h000A);
      chk(rsp_rdata_out, exp_read(a, l));
      @(posedge mclk_in);
      #1;
      chk(16'(rsp_valid_out), 16'h0000);
    end
  endtask

  // ==========================================================
  // Corner cases, random traffic and a reset in mid-read.
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    #1;
    idle_chk();
    foreach (pool[k]) begin
      xfer(1'b1, pool[k], 16'hC3A5 ^ 16'(k), 2'b11);
      for (int l = 0; l < 4; l++) xfer(1'b0, pool[k], 16'h0000, 2'(l));
    end
    xfer(1'b1, pool[0], 16'h1234, 2'b10);
    xfer(1'b1, pool[0], 16'hFFFF, 2'b00);
    xfer(1'b0, pool[0], 16'h0000, 2'b11);
    repeat (60) begin
      seed = lfsr_next(seed);
      xfer(seed[0], pool[seed[3:2]], seed[31:16], seed[5:4]);
    end
    // The request must meet ready, or the reset lands on an idle bus.
    wait (req_ready_out === 1'b1);
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_write_in <= 1'b0;
    req_addr_in <= pool[1];
    req_lane_en_in <= 2'b11;
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    idle_chk();
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    xfer(1'b0, pool[1], 16'h0000, 2'b11);
    chk(16'(mem_faults), 16'h0000);
    test_done();
  end
endmodule
